// ---- hw/uart_efr_pkg.sv ----
/*
  Shared constants for the enhanced-feature, divisor and trigger register block of one UART
  channel: register addresses, bank key, field positions, write-lock masks, trigger tables.
  Assumes a 3-bit register address and an 8-bit data bus on the parallel host port.
*/
package uart_efr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DLL = 3'h0;
  localparam logic [2:0] ADDR_DLH = 3'h1;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_FCR = 3'h2;
  localparam logic [2:0] ADDR_IIR = 3'h2;
  localparam logic [2:0] ADDR_EFR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_TCR = 3'h6;
  localparam logic [2:0] ADDR_TLR = 3'h7;
  localparam logic [2:0] ADDR_XOFF2 = 3'h7;
  localparam logic [2:0] ADDR_FIFO_RDY = 3'h7;

  // ----------------------------------------------------------------
  // Bank selection and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
  localparam int LCR_DLAB_BIT = 7;
  localparam int EFR_ENH_BIT = 4;
  localparam int EFR_SPEC_BIT = 5;
  localparam int EFR_ARTS_BIT = 6;
  localparam int EFR_ACTS_BIT = 7;
  localparam int IER_SLEEP_BIT = 4;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_TX_SEL_LSB = 4;
  localparam int FCR_RX_SEL_LSB = 6;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_RDY_EN_BIT = 2;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MCR_TCR_BIT = 6;
  localparam int IIR_NOINT_BIT = 0;
  localparam int IIR_SPEC_BIT = 4;
  localparam int IIR_MIRROR_LO = 6;
  localparam int IIR_MIRROR_HI = 7;
  localparam int MSR_RI_BIT = 6;
  localparam int RDY_TX_A_BIT = 0;
  localparam int RDY_TX_B_BIT = 1;
  localparam int RDY_RX_A_BIT = 4;
  localparam int RDY_RX_B_BIT = 5;

  // Bits guarded by the enhanced write enable
  localparam logic [7:0] IER_LOCK_MASK = 8'hf0;
  localparam logic [7:0] FCR_LOCK_MASK = 8'h30;
  localparam logic [7:0] MCR_LOCK_MASK = 8'he0;

  // ----------------------------------------------------------------
  // Trigger levels (field value times four)
  // ----------------------------------------------------------------
  localparam int TRIG_SHIFT = 2;
  localparam logic [6:0] TX_FCR_LVL [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
  localparam logic [6:0] RX_FCR_LVL [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};

  typedef enum logic [1:0] {
    RTS_GO = 2'b01,
    RTS_HALT = 2'b10
  } rts_state_t;

endpackage : uart_efr_pkg

// ---- hw/trigger_level_pick.sv ----
/*
  Effective FIFO trigger level for one direction: a nonzero programmed field wins,
  otherwise the two-bit FIFO-control selection picks from a fixed table.
  Assumes purely combinational use inside the register block.
*/
`timescale 1ns/1ps
module trigger_level_pick (
  input wire logic [3:0] tlr_field_in,
  input wire logic [1:0] fcr_sel_in,
  input wire logic rx_dir_in,
  output logic [6:0] level_out
);

  always_comb begin
    if (tlr_field_in != 4'h0) begin
      level_out = 7'(tlr_field_in) << uart_efr_pkg::TRIG_SHIFT;
    end else if (rx_dir_in) begin
      level_out = uart_efr_pkg::RX_FCR_LVL[fcr_sel_in];
    end else begin
      level_out = uart_efr_pkg::TX_FCR_LVL[fcr_sel_in];
    end
  end

endmodule : trigger_level_pick

// ---- hw/uart_enhanced_flow_trigger_regs.sv ----
/*
  Enhanced-feature control, baud divisor latches, flow thresholds, trigger levels and the
  shared FIFO-ready status of one UART channel, behind the parallel host bus.
  Assumes bus pins and the CTS pin are asynchronous; FIFO levels, receive characters and the
  other channel's ready bits come from logic on the same clock.
*/
// Contract
// - Low feature bits select software flow mode
// - Feature bit 4 gates locked control bits
// - Second stop character sets detect flag
// - Auto RTS halts and restores at thresholds
// - Auto CTS halts transmission on high CTS
// - Divisor is high latch then low latch
// - Divisor writable only while sleep disabled
// - Threshold fields: halt low, restore high nibble
// - Threshold writes need enable and modem bit 6
// - Trigger fields: transmit low, receive high nibble
// - Trigger writes need enable and modem bit 6
// - Zero trigger field falls back to FIFO control
// - Ready bits 0,1 show transmit space
// - Ready bits 4,5 show receive data or timeout
// - Ready register read-only at address seven
// - Modem bit 6 maps threshold and trigger registers
// - Modem bit 2 enables ready, loopback mirrors
`timescale 1ns/1ps
module uart_enhanced_flow_trigger_regs (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic chip_select_chan_a_n_in,
  input wire logic chip_select_chan_b_n_in,
  input wire logic write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic cts_n_in,
  input wire logic [6:0] rx_level_in,
  input wire logic [6:0] tx_space_in,
  input wire logic rx_timeout_in,
  input wire logic rx_char_valid_in,
  input wire logic [7:0] rx_char_in,
  input wire logic tx_busy_in,
  input wire logic chan_b_tx_ready_in,
  input wire logic chan_b_rx_ready_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic rts_n_out,
  output logic tx_permit_out,
  output logic [15:0] baud_divisor_out,
  output logic [6:0] tx_trigger_out,
  output logic [6:0] rx_trigger_out,
  output logic special_char_out,
  output logic [3:0] sw_flow_mode_out,
  output logic sleep_mode_out,
  output logic loopback_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Synchronised strobes are stored active high so an all-zero reset means idle
  typedef struct packed {
    logic cs_a_s1;
    logic cs_a_s2;
    logic cs_b_s1;
    logic cs_b_s2;
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    logic rd_s1;
    logic rd_s2;
    logic rd_s3;
    logic cts_s1;
    logic cts_s2;
    logic [2:0] addr_s1;
    logic [2:0] addr_s2;
    logic [7:0] din_s1;
    logic [7:0] din_s2;
    logic wr_cs;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_iir;
    logic [7:0] lcr;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] fifo_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] efr;
    logic [7:0] dll;
    logic [7:0] baud_divisor_high;
    logic [7:0] flow_threshold_ctrl;
    logic [7:0] fifo_trigger_level;
    logic [7:0] xoff2;
    uart_efr_pkg::rts_state_t rts_st;
    logic rts_n;
    logic tx_permit;
    logic spec_flag;
    logic [7:0] rd_data;
    logic data_oe;
    logic [6:0] tx_trig;
    logic [6:0] rx_trig;
  } state_t;

  state_t q_r;
  state_t q_nxt;
  logic [6:0] tx_lvl;
  logic [6:0] rx_lvl;

  // Keeps the unchanged bits of a locked field when the enable is off
  function automatic logic [7:0] guarded(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] mask, input logic en);
    guarded = en ? new_v : ((new_v & ~mask) | (old_v & mask));
  endfunction : guarded

  // ----------------------------------------------------------------
  // Effective trigger levels
  // ----------------------------------------------------------------
  trigger_level_pick tx_pick (
    .tlr_field_in(q_r.fifo_trigger_level[3:0]),
    .fcr_sel_in(q_r.fifo_control_reg[uart_efr_pkg::FCR_TX_SEL_LSB +: 2]),
    .rx_dir_in(1'b0),
    .level_out(tx_lvl)
  );

  trigger_level_pick rx_pick (
    .tlr_field_in(q_r.fifo_trigger_level[7:4]),
    .fcr_sel_in(q_r.fifo_control_reg[uart_efr_pkg::FCR_RX_SEL_LSB +: 2]),
    .rx_dir_in(1'b1),
    .level_out(rx_lvl)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic enh;
    logic dlab;
    logic tcr_acc;
    logic loop;
    logic rdy_acc;
    logic wr_end;
    logic rd_act;
    logic norm;
    logic spec_hit;
    logic [7:0] rdy;
    logic [7:0] interrupt_ident_reg;
    logic [7:0] modem_status_reg;
    logic [7:0] rd_byte;
    logic [6:0] halt_lvl;
    logic [6:0] rest_lvl;
    enh = (q_r.lcr == uart_efr_pkg::LCR_ENH_KEY);
    dlab = q_r.lcr[uart_efr_pkg::LCR_DLAB_BIT] && !enh;
    norm = !enh && !dlab;
    tcr_acc = q_r.efr[uart_efr_pkg::EFR_ENH_BIT] && q_r.modem_control_reg[uart_efr_pkg::MCR_TCR_BIT];
    loop = q_r.modem_control_reg[uart_efr_pkg::MCR_LOOP_BIT];
    rdy_acc = q_r.modem_control_reg[uart_efr_pkg::MCR_RDY_EN_BIT] && !loop && !tcr_acc && norm;
    wr_end = q_r.wr_s3 && !q_r.wr_s2;
    rd_act = q_r.rd_s2 && (q_r.cs_a_s2 || (q_r.cs_b_s2 && rdy_acc));
    halt_lvl = 7'(q_r.flow_threshold_ctrl[3:0]) << uart_efr_pkg::TRIG_SHIFT;
    rest_lvl = 7'(q_r.flow_threshold_ctrl[7:4]) << uart_efr_pkg::TRIG_SHIFT;
    spec_hit = q_r.efr[uart_efr_pkg::EFR_SPEC_BIT] && rx_char_valid_in
               && (rx_char_in == q_r.xoff2);
    rdy = 8'h00;
    rdy[uart_efr_pkg::RDY_TX_A_BIT] = (tx_space_in >= tx_lvl);
    rdy[uart_efr_pkg::RDY_TX_B_BIT] = chan_b_tx_ready_in;
    rdy[uart_efr_pkg::RDY_RX_A_BIT] = (rx_level_in > rx_lvl) || rx_timeout_in;
    rdy[uart_efr_pkg::RDY_RX_B_BIT] = chan_b_rx_ready_in;
    interrupt_ident_reg = 8'h00;
    interrupt_ident_reg[uart_efr_pkg::IIR_NOINT_BIT] = !q_r.spec_flag;
    interrupt_ident_reg[uart_efr_pkg::IIR_SPEC_BIT] = q_r.spec_flag;
    interrupt_ident_reg[uart_efr_pkg::IIR_MIRROR_LO] = q_r.fifo_control_reg[uart_efr_pkg::FCR_EN_BIT];
    interrupt_ident_reg[uart_efr_pkg::IIR_MIRROR_HI] = q_r.fifo_control_reg[uart_efr_pkg::FCR_EN_BIT];
    modem_status_reg = 8'h00;
    modem_status_reg[uart_efr_pkg::MSR_RI_BIT] = loop && q_r.modem_control_reg[uart_efr_pkg::MCR_RDY_EN_BIT];
    rd_byte = 8'h00;
    q_nxt = q_r;

    // Two-stage synchronisers on every pin
    q_nxt.cs_a_s1 = !chip_select_chan_a_n_in;
    q_nxt.cs_a_s2 = q_r.cs_a_s1;
    q_nxt.cs_b_s1 = !chip_select_chan_b_n_in;
    q_nxt.cs_b_s2 = q_r.cs_b_s1;
    q_nxt.wr_s1 = !write_strobe_n_in;
    q_nxt.wr_s2 = q_r.wr_s1;
    q_nxt.wr_s3 = q_r.wr_s2;
    q_nxt.rd_s1 = !read_strobe_n_in;
    q_nxt.rd_s2 = q_r.rd_s1;
    q_nxt.rd_s3 = q_r.rd_s2;
    q_nxt.cts_s1 = cts_n_in;
    q_nxt.cts_s2 = q_r.cts_s1;
    q_nxt.addr_s1 = addr_in;
    q_nxt.addr_s2 = q_r.addr_s1;
    q_nxt.din_s1 = data_in;
    q_nxt.din_s2 = q_r.din_s1;

    // Address and data are held from the last strobe-active cycle, so the host
    // may change them together with the trailing edge of the write strobe
    if (q_r.wr_s2) begin
      q_nxt.wr_cs = q_r.cs_a_s2;
      q_nxt.wr_addr = q_r.addr_s2;
      q_nxt.wr_data = q_r.din_s2;
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (wr_end && q_r.wr_cs) begin
      if (q_r.wr_addr == uart_efr_pkg::ADDR_LCR) begin
        q_nxt.lcr = q_r.wr_data;
      end else if (enh) begin
        case (q_r.wr_addr)
          uart_efr_pkg::ADDR_EFR: q_nxt.efr = q_r.wr_data;
          uart_efr_pkg::ADDR_XOFF2: q_nxt.xoff2 = q_r.wr_data;
          default: q_nxt.efr = q_r.efr;
        endcase
      end else if (dlab) begin
        if (!q_r.interrupt_enable_reg[uart_efr_pkg::IER_SLEEP_BIT]) begin
          case (q_r.wr_addr)
            uart_efr_pkg::ADDR_DLL: q_nxt.dll = q_r.wr_data;
            uart_efr_pkg::ADDR_DLH: q_nxt.baud_divisor_high = q_r.wr_data;
            default: q_nxt.dll = q_r.dll;
          endcase
        end
      end else begin
        case (q_r.wr_addr)
          uart_efr_pkg::ADDR_IER: begin
            q_nxt.interrupt_enable_reg = guarded(q_r.interrupt_enable_reg, q_r.wr_data, uart_efr_pkg::IER_LOCK_MASK,
                                q_r.efr[uart_efr_pkg::EFR_ENH_BIT]);
          end
          uart_efr_pkg::ADDR_FCR: begin
            q_nxt.fifo_control_reg = guarded(q_r.fifo_control_reg, q_r.wr_data, uart_efr_pkg::FCR_LOCK_MASK,
                                q_r.efr[uart_efr_pkg::EFR_ENH_BIT]);
          end
          uart_efr_pkg::ADDR_MCR: begin
            q_nxt.modem_control_reg = guarded(q_r.modem_control_reg, q_r.wr_data, uart_efr_pkg::MCR_LOCK_MASK,
                                q_r.efr[uart_efr_pkg::EFR_ENH_BIT]);
          end
          uart_efr_pkg::ADDR_TCR: begin
            if (tcr_acc) begin
              q_nxt.flow_threshold_ctrl = q_r.wr_data;
            end
          end
          uart_efr_pkg::ADDR_TLR: begin
            if (tcr_acc) begin
              q_nxt.fifo_trigger_level = q_r.wr_data;
            end
          end
          default: q_nxt.lcr = q_r.lcr;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    if (q_r.cs_a_s2) begin
      if (q_r.addr_s2 == uart_efr_pkg::ADDR_LCR) begin
        rd_byte = q_r.lcr;
      end else if (enh) begin
        case (q_r.addr_s2)
          uart_efr_pkg::ADDR_EFR: rd_byte = q_r.efr;
          uart_efr_pkg::ADDR_XOFF2: rd_byte = q_r.xoff2;
          default: rd_byte = 8'h00;
        endcase
      end else if (dlab) begin
        case (q_r.addr_s2)
          uart_efr_pkg::ADDR_DLL: rd_byte = q_r.dll;
          uart_efr_pkg::ADDR_DLH: rd_byte = q_r.baud_divisor_high;
          default: rd_byte = 8'h00;
        endcase
      end else begin
        case (q_r.addr_s2)
          uart_efr_pkg::ADDR_IER: rd_byte = q_r.interrupt_enable_reg;
          uart_efr_pkg::ADDR_IIR: rd_byte = interrupt_ident_reg;
          uart_efr_pkg::ADDR_MCR: rd_byte = q_r.modem_control_reg;
          uart_efr_pkg::ADDR_TCR: rd_byte = tcr_acc ? q_r.flow_threshold_ctrl : modem_status_reg;
          uart_efr_pkg::ADDR_TLR: rd_byte = tcr_acc ? q_r.fifo_trigger_level : (rdy_acc ? rdy : 8'h00);
          default: rd_byte = 8'h00;
        endcase
      end
    end else if (q_r.addr_s2 == uart_efr_pkg::ADDR_FIFO_RDY) begin
      rd_byte = rdy;
    end
    q_nxt.data_oe = rd_act;
    if (rd_act) begin
      q_nxt.rd_data = rd_byte;
      q_nxt.rd_iir = q_r.cs_a_s2 && norm && (q_r.addr_s2 == uart_efr_pkg::ADDR_IIR);
    end

    // ----------------------------------------------------------------
    // Special character flag: cleared when an identification read ends
    // ----------------------------------------------------------------
    if (q_r.rd_s3 && !q_r.rd_s2 && q_r.rd_iir) begin
      q_nxt.spec_flag = 1'b0;
    end
    if (spec_hit) begin
      q_nxt.spec_flag = 1'b1;
    end

    // ----------------------------------------------------------------
    // Hardware flow control
    // ----------------------------------------------------------------
    // Hysteresis relies on the host keeping halt above restore
    case (q_r.rts_st)
      uart_efr_pkg::RTS_GO: begin
        if (q_r.efr[uart_efr_pkg::EFR_ARTS_BIT] && (rx_level_in >= halt_lvl)) begin
          q_nxt.rts_st = uart_efr_pkg::RTS_HALT;
        end
      end
      uart_efr_pkg::RTS_HALT: begin
        if (!q_r.efr[uart_efr_pkg::EFR_ARTS_BIT] || (rx_level_in <= rest_lvl)) begin
          q_nxt.rts_st = uart_efr_pkg::RTS_GO;
        end
      end
      default: q_nxt.rts_st = uart_efr_pkg::RTS_GO;
    endcase
    if (q_r.efr[uart_efr_pkg::EFR_ARTS_BIT]) begin
      q_nxt.rts_n = (q_nxt.rts_st == uart_efr_pkg::RTS_HALT);
    end else begin
      q_nxt.rts_n = !q_r.modem_control_reg[uart_efr_pkg::MCR_RTS_BIT];
    end

    // A character in flight always finishes; the gate moves between characters
    if (!tx_busy_in) begin
      q_nxt.tx_permit = !(q_r.efr[uart_efr_pkg::EFR_ACTS_BIT] && q_r.cts_s2);
    end

    q_nxt.tx_trig = tx_lvl;
    q_nxt.rx_trig = rx_lvl;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= '0;
      q_r.rts_st <= uart_efr_pkg::RTS_GO;
      q_r.rts_n <= 1'b1;
      q_r.tx_permit <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_out = q_r.rd_data;
  assign data_oe_out = q_r.data_oe;
  assign rts_n_out = q_r.rts_n;
  assign tx_permit_out = q_r.tx_permit;
  assign baud_divisor_out = {q_r.baud_divisor_high, q_r.dll};
  assign tx_trigger_out = q_r.tx_trig;
  assign rx_trigger_out = q_r.rx_trig;
  assign special_char_out = q_r.spec_flag;
  assign sw_flow_mode_out = q_r.efr[3:0];
  assign sleep_mode_out = q_r.interrupt_enable_reg[uart_efr_pkg::IER_SLEEP_BIT];
  assign loopback_out = q_r.modem_control_reg[uart_efr_pkg::MCR_LOOP_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  logic chk_wr_end;
  logic chk_norm;
  assign chk_wr_end = q_r.wr_s3 && !q_r.wr_s2 && q_r.wr_cs;
  assign chk_norm = !q_r.lcr[uart_efr_pkg::LCR_DLAB_BIT];

  chk_efr_mode_load: assert property (
    chk_wr_end && q_r.lcr == uart_efr_pkg::LCR_ENH_KEY && q_r.wr_addr == uart_efr_pkg::ADDR_EFR
    |=> sw_flow_mode_out == $past(q_r.wr_data[3:0]))
    else $error("flow mode not taken from feature write");
  chk_ier_lock_hold: assert property (
    chk_wr_end && chk_norm && q_r.wr_addr == uart_efr_pkg::ADDR_IER
    && !q_r.efr[uart_efr_pkg::EFR_ENH_BIT] |=> $stable(q_r.interrupt_enable_reg[7:4]))
    else $error("locked interrupt enable bits changed");
  chk_spec_char_set: assert property (
    q_r.efr[uart_efr_pkg::EFR_SPEC_BIT] && rx_char_valid_in && rx_char_in == q_r.xoff2
    |=> special_char_out)
    else $error("special character not flagged");
  chk_rts_halt_level: assert property (
    q_r.efr[uart_efr_pkg::EFR_ARTS_BIT] && rx_level_in >= (7'(q_r.flow_threshold_ctrl[3:0]) << 2)
    |=> rts_n_out)
    else $error("rts not raised at halt threshold");
  chk_rts_restore_lvl: assert property (
    q_r.efr[uart_efr_pkg::EFR_ARTS_BIT] && rts_n_out && rx_level_in <= (7'(q_r.flow_threshold_ctrl[7:4]) << 2)
    && rx_level_in < (7'(q_r.flow_threshold_ctrl[3:0]) << 2) |=> !rts_n_out)
    else $error("rts not lowered at restore threshold");
  chk_cts_tx_halt: assert property (
    q_r.efr[uart_efr_pkg::EFR_ACTS_BIT] && q_r.cts_s2 && !tx_busy_in |=> !tx_permit_out)
    else $error("transmission not halted by cts");
  chk_tx_char_whole: assert property (
    tx_busy_in |=> $stable(tx_permit_out))
    else $error("transmit gate moved inside a character");
  chk_div_sleep_lock: assert property (
    chk_wr_end && q_r.interrupt_enable_reg[uart_efr_pkg::IER_SLEEP_BIT] |=> $stable(baud_divisor_out))
    else $error("divisor written during sleep");
  chk_tcr_write_lock: assert property (
    !(q_r.efr[uart_efr_pkg::EFR_ENH_BIT] && q_r.modem_control_reg[uart_efr_pkg::MCR_TCR_BIT])
    |=> $stable(q_r.flow_threshold_ctrl) && $stable(q_r.fifo_trigger_level))
    else $error("threshold or trigger written while locked");
  chk_tlr_override: assert property (
    q_r.fifo_trigger_level[3:0] != 4'h0 |=> tx_trigger_out == (7'($past(q_r.fifo_trigger_level[3:0])) << 2))
    else $error("nonzero trigger field not applied");

  cov_auto_rts_cycle: cover property (rts_n_out && q_r.efr[uart_efr_pkg::EFR_ARTS_BIT]
    ##[1:1000] !rts_n_out);
  cov_special_char: cover property (!special_char_out ##1 special_char_out);
  cov_ready_read: cover property (data_oe_out && q_r.cs_b_s2 && !q_r.cs_a_s2);
  cov_cts_halt: cover property (tx_permit_out ##1 !tx_permit_out);

endmodule : uart_enhanced_flow_trigger_regs

// ---- test/host_bus_model.sv ----
/*
  Host side of the parallel register port: one bus access per task call.
  Assumes the bench calls access() and that the block samples strobes on mclk_in.
*/
`timescale 1ns/1ps
module host_bus_model (
  input wire logic mclk_in,
  input wire logic [7:0] rd_data_in,
  input wire logic oe_in,
  output logic cs_a_n_out,
  output logic cs_b_n_out,
  output logic wr_n_out,
  output logic rd_n_out,
  output logic [2:0] addr_out,
  output logic [7:0] data_out
);
  initial begin
    {cs_a_n_out, cs_b_n_out, wr_n_out, rd_n_out} = 4'hf;
    addr_out = 3'h0;
    data_out = 8'h00;
  end
  // Five cycles low and high each, above the three-flop sync minimum
  task automatic access(input logic wr, input logic use_b, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk_in);
    addr_out = a;
    data_out = d;
    cs_a_n_out = use_b;
    cs_b_n_out = ~use_b;
    if (wr) wr_n_out = 1'b0;
    else rd_n_out = 1'b0;
    repeat (5) @(negedge mclk_in);
    // Undriven bus reads as unknown so a missing enable fails the compare
    q = oe_in ? rd_data_in : 8'hxx;
    {cs_a_n_out, cs_b_n_out, wr_n_out, rd_n_out} = 4'hf;
    // Released lines show the inverse, never a stale value
    data_out = ~d;
    addr_out = ~a;
    repeat (5) @(negedge mclk_in);
  endtask : access
endmodule : host_bus_model

// ---- test/uart_enhanced_flow_trigger_regs_bench.sv ----
/*
  Self-checking bench for the enhanced-feature register block.
  Assumes host_bus_model drives the bus; FIFO side is driven here.
*/
`timescale 1ns/1ps
module uart_enhanced_flow_trigger_regs_bench;
  logic mclk_in, rst_n_in, chip_select_chan_a_n_in, chip_select_chan_b_n_in;
  logic write_strobe_n_in, read_strobe_n_in, cts_n_in, rx_timeout_in, rx_char_valid_in;
  logic tx_busy_in, chan_b_tx_ready_in, chan_b_rx_ready_in, data_oe_out, rts_n_out;
  logic tx_permit_out, special_char_out, sleep_mode_out, loopback_out;
  logic [2:0] addr_in;
  logic [7:0] data_in, data_out, rx_char_in, q, lo, hi, m, tl;
  logic [6:0] rx_level_in, tx_space_in, tx_trigger_out, rx_trigger_out, ttx, trx;
  logic [15:0] baud_divisor_out;
  logic [3:0] sw_flow_mode_out;
  logic [31:0] seed = 32'h99bcc55f;
  logic [6:0] lv [5] = '{7'h00, 7'h1f, 7'h20, 7'h09, 7'h08};
  logic [4:0] rexp = 5'h0c;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  host_bus_model host (.mclk_in, .rd_data_in(data_out), .oe_in(data_oe_out),
    .cs_a_n_out(chip_select_chan_a_n_in), .cs_b_n_out(chip_select_chan_b_n_in),
    .wr_n_out(write_strobe_n_in), .rd_n_out(read_strobe_n_in), .addr_out(addr_in),
    .data_out(data_in));
  uart_enhanced_flow_trigger_regs dut (.mclk_in, .rst_n_in, .chip_select_chan_a_n_in,
    .chip_select_chan_b_n_in, .write_strobe_n_in, .read_strobe_n_in, .addr_in, .data_in,
    .cts_n_in, .rx_level_in, .tx_space_in, .rx_timeout_in, .rx_char_valid_in, .rx_char_in,
    .tx_busy_in, .chan_b_tx_ready_in, .chan_b_rx_ready_in, .data_out, .data_oe_out,
    .rts_n_out, .tx_permit_out, .baud_divisor_out, .tx_trigger_out, .rx_trigger_out,
    .special_char_out, .sw_flow_mode_out, .sleep_mode_out, .loopback_out);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [6:0] trig(input logic [3:0] f, input logic [1:0] sel,
                                      input logic rx);
    if (f != 4'h0) return {1'b0, f, 2'b00};
    return rx ? uart_efr_pkg::RX_FCR_LVL[sel] : uart_efr_pkg::TX_FCR_LVL[sel];
  endfunction : trig
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host.access(1'b1, 1'b0, a, d, q);
  endtask : wr
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Whole run needs about 490 cycles
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      $display("[ERR] %0t run did not finish", $time);
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n_in, cts_n_in, rx_timeout_in, rx_char_valid_in, tx_busy_in} = 5'h00;
    {chan_b_tx_ready_in, chan_b_rx_ready_in} = 2'h0;
    {rx_level_in, tx_space_in, rx_char_in} = 22'h000000;
    repeat (5) @(negedge mclk_in);
    rst_n_in = 1'b1;
    chk({rts_n_out, tx_permit_out, baud_divisor_out}, 18'h30000, "reset");
    wr(3'h3, 8'h00);
    wr(3'h1, 8'hf0);
    chk(sleep_mode_out, 1'b0, "locked sleep bit");
    seed = lfsr(seed);
    {m, hi, lo} = seed[23:0];
    wr(3'h3, 8'h80);
    wr(3'h0, lo);
    wr(3'h1, hi);
    chk(baud_divisor_out, {hi, lo}, "divisor");
    wr(3'h3, 8'hbf);
    wr(3'h2, {4'h1, m[3:0]});
    chk(sw_flow_mode_out, m[3:0], "flow mode");
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h10);
    chk(sleep_mode_out, 1'b1, "sleep unlocked");
    wr(3'h3, 8'h80);
    wr(3'h0, ~lo);
    chk(baud_divisor_out, {hi, lo}, "divisor in sleep");
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h7, 8'h55);
    chk({tx_trigger_out, rx_trigger_out}, {7'h08, 7'h08}, "trigger unmapped");
    wr(3'h4, 8'h40);
    wr(3'h7, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(3'h2, {i[1:0], i[1:0], 4'h1});
      chk({tx_trigger_out, rx_trigger_out}, {trig(4'h0, i[1:0], 1'b0),
        trig(4'h0, i[1:0], 1'b1)}, "fcr trigger");
    end
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      tl = (i == 0) ? 8'hf1 : seed[7:0];
      wr(3'h7, tl);
      ttx = trig(tl[3:0], 2'h3, 1'b0);
      trx = trig(tl[7:4], 2'h3, 1'b1);
      chk({tx_trigger_out, rx_trigger_out}, {ttx, trx}, "tlr");
    end
    wr(3'h6, 8'h28);
    wr(3'h3, 8'hbf);
    wr(3'h2, {4'hd, m[3:0]});
    foreach (lv[k]) begin
      rx_level_in = lv[k];
      repeat (3) @(negedge mclk_in);
      chk(rts_n_out, rexp[k], "auto rts");
    end
    tx_busy_in = 1'b1;
    cts_n_in = 1'b1;
    repeat (5) @(negedge mclk_in);
    chk(tx_permit_out, 1'b1, "char in progress");
    tx_busy_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk(tx_permit_out, 1'b0, "cts halt");
    cts_n_in = 1'b0;
    repeat (5) @(negedge mclk_in);
    chk(tx_permit_out, 1'b1, "cts resume");
    wr(3'h7, 8'h13);
    wr(3'h2, {4'hf, m[3:0]});
    for (int i = 0; i < 2; i++) begin
      rx_char_in = i ? 8'h13 : 8'h31;
      rx_char_valid_in = 1'b1;
      @(negedge mclk_in);
      rx_char_valid_in = 1'b0;
      rx_char_in = ~rx_char_in;
      @(negedge mclk_in);
      chk(special_char_out, i[0], "special char");
    end
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h04);
    wr(3'h7, 8'hff);
    chk({tx_trigger_out, rx_trigger_out}, {ttx, trx}, "ready is read-only");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      tx_space_in = seed[6] ? 7'h40 : {1'b0, seed[5:0]};
      rx_level_in = seed[13] ? 7'h40 : {1'b0, seed[12:7]};
      if (i < 2) begin
        tx_space_in = ttx - 7'(i);
        rx_level_in = trx + 7'(i);
      end
      rx_timeout_in = seed[14] & (i > 1);
      {chan_b_tx_ready_in, chan_b_rx_ready_in} = seed[16:15];
      host.access(1'b0, seed[17], 3'h7, 8'h00, q);
      chk(q, {2'b00, chan_b_rx_ready_in, rx_timeout_in | (rx_level_in > trx), 2'b00,
        chan_b_tx_ready_in, tx_space_in >= ttx}, "ready");
    end
    wr(3'h4, 8'h14);
    host.access(1'b0, 1'b0, 3'h7, 8'h00, q);
    chk({loopback_out, q}, 9'h100, "ready off in loopback");
    end_of_test();
  end
endmodule : uart_enhanced_flow_trigger_regs_bench
